// ==== core/acs_amp_ctrl.sv ====
`timescale 1ns/1ps
module acs_amp_ctrl
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Strap pins and switching start
  input  wire logic [3:0] adsel_code_i,
  input  wire logic [2:0] cfg_strap_i,
  input  wire logic       switch_start_i,
  // Analog diagnostics
  input  wire logic       ovp_i,
  input  wire logic       uvp_i,
  input  wire logic       otp_i,
  input  wire logic       prewarn_i,
  input  wire logic       dc_valid_i,
  input  wire logic       ac_load_i,
  input  wire logic       parallel_i,
  input  wire logic [1:0] short_vp_i,
  input  wire logic [1:0] short_gnd_i,
  input  wire logic [1:0] shorted_load_i,
  input  wire logic [1:0] open_load_i,
  input  wire logic [1:0] offset_i,
  input  wire logic [1:0] clip_i,
  // Indicator pins
  output logic            fault_ind_o,
  output logic            sat_ind_o,
  // Amplifier controls
  output logic            run_o,
  output logic            mute_o,
  output logic [1:0]      ch_dis_o,
  output logic            hop_en_o,
  output logic            osc_up_o,
  output logic            pw_low_o,
  output logic            dc_det_en_o,
  output logic            ac_det_en_o,
  output logic [2:0]      phase_o,
  output logic            bd_mod_o,
  output logic            ofs_prot_off_o,
  output logic [1:0]      ofs_mon_off_o,
  output logic [6:0]      dev_addr_o
);
  localparam int NIN = 29;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic           scl_s, sda_s, ovp_s, uvp_s, otp_s, pw_s, dcv_s, acl_s, par_s, sst_s;
  logic [1:0]     svp_s, sg_s, shl_s, opn_s, ofs_s, clip_s;
  logic [3:0]     ads_s;
  logic [2:0]     cfg_s;
  logic           scl_d_reg, sda_d_reg, sst_d_reg;

  acs_state_e     state_reg, state_next;
  logic [3:0]     cnt_reg, cnt_next;
  logic [7:0]     sh_reg, sh_next;
  logic [1:0]     idx_reg, idx_next;
  logic           rw_reg, rw_next;
  logic           oe_reg, oe_next;
  logic           rdact_reg, rdact_next;
  logic [7:0]     snap2_reg, snap2_next;
  logic           rd_done, wr_en, latch_now;

  logic [7:0]     c1_reg, c2_reg, c3_reg;
  logic [7:0]     st1_reg, st1_next, st2_reg, st2_next;
  logic [7:0]     set1, set2;
  logic [6:0]     addr_reg;
  logic [1:0]     boot_reg;
  logic           fault_reg, sat_reg, fault_next, sat_next;

  // Every pin passes two flops before any logic sees it
  assign raw = {scl_i, sda_i, ovp_i, uvp_i, otp_i, prewarn_i, dc_valid_i, ac_load_i,
                parallel_i, switch_start_i, short_vp_i, short_gnd_i, shorted_load_i,
                open_load_i, offset_i, clip_i, adsel_code_i, cfg_strap_i};
  assign {scl_s, sda_s, ovp_s, uvp_s, otp_s, pw_s, dcv_s, acl_s, par_s, sst_s,
          svp_s, sg_s, shl_s, opn_s, ofs_s, clip_s, ads_s, cfg_s} = s2_reg;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sst_d_reg <= 1'b0;
    end else begin
      s1_reg    <= raw;
      s2_reg    <= s1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      sst_d_reg <= sst_s;
    end
  end

  // Bus events seen on the sampled pins
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_done = scl_fall & (cnt_reg == BYTE_BITS);
  wire addr_hit = (sh_reg[7:1] == addr_reg);
  wire [1:0] idx_inc = idx_reg + 2'h1;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    idx_next   = idx_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    rdact_next = rdact_reg;
    snap2_next = snap2_reg;
    rd_done    = 1'b0;
    wr_en      = 1'b0;
    if (bus_start || bus_stop) begin
      // Repeated start or stop aborts any byte in flight
      state_next = bus_start ? ST_ADDR : ST_IDLE;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      rdact_next = 1'b0;
      rd_done    = rdact_reg;
    end else begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (state_reg == ST_ADDR) begin
              state_next = addr_hit ? ST_AACK : ST_IDLE;
              oe_next    = addr_hit;
              rw_next    = sh_reg[0];
            end else begin
              // Bytes past the third are not acknowledged
              state_next = (idx_reg < NUM_CTRL) ? ST_WACK : ST_IDLE;
              oe_next    = (idx_reg < NUM_CTRL);
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            idx_next = 2'h0;
            if (rw_reg == RW_READ) begin
              state_next = ST_RBYTE;
              sh_next    = st1_reg;
              snap2_next = st2_reg;
              oe_next    = ~st1_reg[7];
              rdact_next = 1'b1;
            end else begin
              state_next = ST_WBYTE;
              oe_next    = 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            wr_en      = 1'b1;
            idx_next   = idx_inc;
            oe_next    = 1'b0;
            cnt_next   = 4'h0;
            state_next = ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_done) begin
            oe_next    = 1'b0;
            state_next = ST_RACK;
          end else if (scl_fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            // Missing acknowledge ends the read
            state_next = ST_IDLE;
            rd_done    = 1'b1;
            rdact_next = 1'b0;
          end else if (scl_fall) begin
            idx_next   = {1'b0, ~idx_reg[0]};
            sh_next    = idx_reg[0] ? st1_reg : snap2_reg;
            oe_next    = idx_reg[0] ? ~st1_reg[7] : ~snap2_reg[7];
            cnt_next   = 4'h0;
            state_next = ST_RBYTE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      idx_reg   <= 2'h0;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      rdact_reg <= 1'b0;
      snap2_reg <= STAT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      idx_reg   <= idx_next;
      rw_reg    <= rw_next;
      oe_reg    <= oe_next;
      rdact_reg <= rdact_next;
      snap2_reg <= snap2_next;
    end
  end

  // Control bytes; host keeps unused bits at zero after power-on
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c1_reg <= CTRL_RST;
      c2_reg <= CTRL_RST;
      c3_reg <= CTRL_RST;
    end else if (wr_en) begin
      if (idx_reg == 2'h0) c1_reg <= sh_reg;
      if (idx_reg == 2'h1) c2_reg <= sh_reg;
      if (idx_reg == 2'h2) c3_reg <= sh_reg;
    end
  end

  // Straps latch once the synchronisers hold pin levels, not their reset zeros
  assign latch_now = (boot_reg == SYNC_FILL) | (sst_s & ~sst_d_reg & ~c3_reg[C3_LATCH])
                   | (wr_en & (idx_reg == 2'h2) & sh_reg[C3_LATCH]);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_reg     <= 2'h0;
      addr_reg     <= ADDR_RST;
    end else begin
      if (!(&boot_reg)) boot_reg <= boot_reg + 2'h1;
      if (latch_now) addr_reg <= {cfg_s, ads_s};
    end
  end

  // Parallel mode folds both channels into byte one
  wire [1:0] f_svp = par_s ? {1'b0, |svp_s} : svp_s;
  wire [1:0] f_sg  = par_s ? {1'b0, |sg_s} : sg_s;
  wire [1:0] f_shl = par_s ? {1'b0, |shl_s} : shl_s;
  wire [1:0] f_opn = par_s ? {1'b0, |opn_s} : opn_s;
  wire ofs_set = ~c2_reg[C2_PROT_OFF]
               & ((ofs_s[0] & ~c1_reg[C1_MON_OFF]) | (ofs_s[1] & ~c2_reg[C2_MON_OFF]));
  wire all_zero = ~|{c1_reg, c2_reg, c3_reg};
  assign set1 = {2'b00, ovp_s, 1'b0, f_shl[0], ofs_set, f_svp[0], f_sg[0]};
  assign set2 = {otp_s, pw_s, uvp_s, 1'b0, f_shl[1], 1'b0, f_svp[1], f_sg[1]};

  // Set wins over the read clear so no event is lost
  always_comb begin
    st1_next = (st1_reg & ~({8{rd_done}} & ~S1_KEEP)) | set1;
    st2_next = (st2_reg & ~({8{rd_done}} & ~S2_KEEP)) | set2;
    st1_next[S1_ALLZ] = all_zero;
    st1_next[S1_DCV]  = dcv_s & c2_reg[C2_DC_EN];
    st1_next[S_OPEN]  = f_opn[0];
    st2_next[S_OPEN]  = f_opn[1];
  end

  assign fault_next = st1_reg[S1_ALLZ]
                    | (st1_reg[S1_OFS] & ~c1_reg[C1_OFS_PIN]);
  assign sat_next = (clip_s[0] & ~c1_reg[C1_CLIP]) | (clip_s[1] & ~c2_reg[C2_CLIP])
                  | (pw_s & ~c2_reg[C2_PW_PIN])
                  | (acl_s & c3_reg[C3_AC_EN]);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st1_reg   <= STAT_RST;
      st2_reg   <= STAT_RST;
      fault_reg <= 1'b0;
      sat_reg   <= 1'b0;
    end else begin
      st1_reg   <= st1_next;
      st2_reg   <= st2_next;
      fault_reg <= fault_next;
      sat_reg   <= sat_next;
    end
  end

  // Outputs straight from flops; the pin level is always low when enabled
  assign sda_o          = 1'b0;
  assign sda_oe_o       = oe_reg;
  assign fault_ind_o    = fault_reg;
  assign sat_ind_o      = sat_reg;
  assign run_o          = c1_reg[C1_RUN];
  assign mute_o         = c2_reg[C2_MUTE];
  assign ch_dis_o       = {c2_reg[C_CH_DIS], c1_reg[C_CH_DIS]};
  assign hop_en_o       = c1_reg[C1_HOP];
  assign osc_up_o       = c1_reg[C1_OSC_UP];
  assign pw_low_o       = c2_reg[C2_PW_LOW];
  assign dc_det_en_o    = c2_reg[C2_DC_EN];
  assign ac_det_en_o    = c3_reg[C3_AC_EN];
  assign phase_o        = c3_reg[C3_PH_HI:C3_PH_LO];
  assign bd_mod_o       = c3_reg[C3_BD];
  assign ofs_prot_off_o = c2_reg[C2_PROT_OFF];
  assign ofs_mon_off_o  = {c2_reg[C2_MON_OFF], c1_reg[C1_MON_OFF]};
  assign dev_addr_o     = addr_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_third_cmd;
    (state_reg == ST_WACK) && scl_fall && (idx_reg == 2'h2) && sh_reg[C3_LATCH];
  endsequence
  sequence s_read_nack;
    (state_reg == ST_RACK) && scl_rise && sda_s && !bus_start && !bus_stop;
  endsequence

  ctrl_commit_a: assert property ((state_reg == ST_WACK) && scl_fall && idx_reg == 2'h0
    |=> c1_reg == $past(sh_reg)) else $error("control byte one not committed");
  strap_cmd_a: assert property (s_third_cmd
    |=> ##1 addr_reg == $past({cfg_s, ads_s}, 2))
    else $error("strap not latched on command");
  all_zero_a: assert property (all_zero [*2] |-> st1_reg[S1_ALLZ])
    else $error("all-zero flag missing");
  fault_pin_a: assert property (st1_reg[S1_ALLZ] |=> fault_ind_o)
    else $error("fault pin not high");
  read_clear_a: assert property (s_read_nack ##0 set2 == 8'h00
    |=> (st2_reg & ~S2_KEEP) == 8'h00)
    else $error("status not cleared after read");
  sticky_hold_a: assert property (st1_reg[S_SVP] && !rd_done |=> st1_reg[S_SVP])
    else $error("short flag dropped before read");
  first_byte_a: assert property ((state_reg == ST_AACK) && scl_fall && rw_reg && !bus_stop
    |=> sda_oe_o == !$past(st1_reg[7]) && sh_reg == $past(st1_reg))
    else $error("read does not open with status one");
  sat_mask_a: assert property ((c1_reg[C1_CLIP] && c2_reg[C2_CLIP] && c2_reg[C2_PW_PIN]
    && !c3_reg[C3_AC_EN]) [*2] |-> !sat_ind_o) else $error("masked source on pin");
  // First edge after reset still holds the reset value of the flag
  reserved_a: assert property (st2_reg[S1_OFS] == 1'b0
    && (!$past(rstn_i) || st1_reg[S1_ALLZ] == $past(all_zero)))
    else $error("reserved status bit set");
  parallel_a: assert property (par_s |=> st2_reg[S_OPEN] == 1'b0)
    else $error("parallel data in byte two");
endmodule

// ==== core/acs_pkg.sv ====
package acs_pkg;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h00;
  localparam logic [6:0] ADDR_RST  = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] NUM_CTRL  = 2'h3;
  localparam logic       RW_READ   = 1'b1;
  localparam logic [1:0] SYNC_FILL = 2'h2;
  // Control byte one fields
  localparam int C1_OFS_PIN = 7;
  localparam int C1_MON_OFF = 6;
  localparam int C1_CLIP    = 5;
  localparam int C1_HOP     = 4;
  localparam int C1_OSC_UP  = 3;
  localparam int C_CH_DIS   = 1;
  localparam int C1_RUN     = 0;
  // Control byte two fields
  localparam int C2_PROT_OFF = 7;
  localparam int C2_MON_OFF  = 6;
  localparam int C2_CLIP     = 5;
  localparam int C2_PW_PIN   = 4;
  localparam int C2_PW_LOW   = 3;
  localparam int C2_DC_EN    = 2;
  localparam int C2_MUTE     = 0;
  // Control byte three fields
  localparam int C3_LATCH = 7;
  localparam int C3_AC_EN = 4;
  localparam int C3_PH_HI = 3;
  localparam int C3_PH_LO = 1;
  localparam int C3_BD    = 0;
  // Status fields
  localparam int S1_ALLZ  = 7;
  localparam int S1_DCV   = 6;
  localparam int S1_OVP   = 5;
  localparam int S_OPEN   = 4;
  localparam int S_SHL    = 3;
  localparam int S1_OFS   = 2;
  localparam int S_SVP    = 1;
  localparam int S_SGND   = 0;
  localparam int S2_OTP   = 7;
  localparam int S2_PW    = 6;
  localparam int S2_UVP   = 5;
  localparam logic [7:0] S1_KEEP = 8'h50;
  localparam logic [7:0] S2_KEEP = 8'h10;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_AACK  = 7'h04,
    ST_WBYTE = 7'h08,
    ST_WACK  = 7'h10,
    ST_RBYTE = 7'h20,
    ST_RACK  = 7'h40
  } acs_state_e;
endpackage

// ==== dv/acs_amp_ctrl_tb.sv ====
`timescale 1ns/1ps
module acs_amp_ctrl_tb;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        scl_i, host_oe, sda_w, sda_o, sda_oe_o;
  logic [3:0]  adsel_code_i = 4'h8;
  logic [2:0]  cfg_strap_i = 3'h5;
  logic        switch_start_i = 1'b0, ovp_i = 1'b0, uvp_i = 1'b0, otp_i = 1'b0;
  logic        prewarn_i = 1'b0, dc_valid_i = 1'b0, ac_load_i = 1'b0, parallel_i = 1'b0;
  logic [1:0]  short_vp_i = 2'h0, short_gnd_i = 2'h0, shorted_load_i = 2'h0;
  logic [1:0]  open_load_i = 2'h0, offset_i = 2'h0, clip_i = 2'h0;
  logic        fault_ind_o, sat_ind_o, run_o, mute_o, hop_en_o, osc_up_o, pw_low_o;
  logic        dc_det_en_o, ac_det_en_o, bd_mod_o, ofs_prot_off_o, nak;
  logic [1:0]  ch_dis_o, ofs_mon_off_o;
  logic [2:0]  phase_o;
  logic [6:0]  dev_addr_o, addr;
  logic [15:0] rdat;
  int          errors = 0;
  int          total_checks = 0;

  always #2 clk_sys_i = ~clk_sys_i;
  // Open-drain wire with pull-up
  assign sda_w = ~host_oe & ~(sda_oe_o & ~sda_o);

  acs_amp_ctrl dut_u (
    .clk_sys_i, .rstn_i, .scl_i, .sda_i(sda_w), .sda_o, .sda_oe_o,
    .adsel_code_i, .cfg_strap_i, .switch_start_i, .ovp_i, .uvp_i, .otp_i,
    .prewarn_i, .dc_valid_i, .ac_load_i, .parallel_i, .short_vp_i, .short_gnd_i,
    .shorted_load_i, .open_load_i, .offset_i, .clip_i, .fault_ind_o, .sat_ind_o,
    .run_o, .mute_o, .ch_dis_o, .hop_en_o, .osc_up_o, .pw_low_o, .dc_det_en_o,
    .ac_det_en_o, .phase_o, .bd_mod_o, .ofs_prot_off_o, .ofs_mon_off_o, .dev_addr_o
  );
  acs_host_model host_u (.scl_o(scl_i), .sda_oe_o(host_oe), .sda_i(sda_w));

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is near 32 us; generous margin
  initial begin
    #300000;
    errors = errors + 1;
    summarize();
  end

  initial begin
    addr = 7'h58;
    step(2);
    rstn_i = 1'b1;
    step(4);
    chk(dev_addr_o, 7'h58);
    chk(fault_ind_o, 1'b1);
    host_u.rd(addr, rdat, nak);
    chk({nak, rdat}, 17'h0_8000);
    // Foreign address is refused and changes nothing
    host_u.wr(7'h11, 24'hFF_FFFF, nak);
    step(4);
    chk({nak, run_o, fault_ind_o}, 3'h5);
    host_u.wr(addr, 24'hDB_8D1B, nak);
    step(4);
    chk(nak, 1'b0);
    chk({run_o, mute_o, ch_dis_o, hop_en_o, osc_up_o, pw_low_o, dc_det_en_o, ac_det_en_o,
         phase_o, bd_mod_o, ofs_prot_off_o, ofs_mon_off_o}, 16'hDFDD);
    chk(fault_ind_o, 1'b0);
    clip_i = 2'h1;
    step(4);
    chk(sat_ind_o, 1'b1);
    clip_i = 2'h2;
    step(4);
    chk(sat_ind_o, 1'b1);
    clip_i = 2'h0;
    step(4);
    chk(sat_ind_o, 1'b0);
    ac_load_i = 1'b1;
    step(4);
    chk(sat_ind_o, 1'b1);
    ac_load_i = 1'b0;
    prewarn_i = 1'b1;
    step(4);
    chk(sat_ind_o, 1'b1);
    // Clip and pre-warning masked while the phase codes step through
    for (int p = 0; p < 6; p++) begin
      host_u.wr(addr, {16'h2134, 4'h0, p[2:0], p[0]}, nak);
      step(4);
      chk({phase_o, bd_mod_o}, {p[2:0], p[0]});
    end
    clip_i = 2'h3;
    step(4);
    chk(sat_ind_o, 1'b0);
    clip_i = 2'h0;
    prewarn_i = 1'b0;
    adsel_code_i = 4'h6;
    switch_start_i = 1'b1;
    step(6);
    chk(dev_addr_o, 7'h56);
    switch_start_i = 1'b0;
    addr = 7'h56;
    adsel_code_i = 4'h2;
    host_u.wr(addr, 24'h01_0480, nak);
    step(4);
    chk(dev_addr_o, 7'h52);
    addr = 7'h52;
    {ovp_i, uvp_i, otp_i, prewarn_i} = 4'hF;
    {short_vp_i, short_gnd_i, shorted_load_i, offset_i} = 8'h69;
    open_load_i = 2'h3;
    dc_valid_i = 1'b1;
    step(2);
    {ovp_i, uvp_i, otp_i, prewarn_i} = 4'h0;
    {short_vp_i, short_gnd_i, shorted_load_i, offset_i} = 8'h00;
    step(6);
    chk(fault_ind_o, 1'b1);
    host_u.rd(addr, rdat, nak);
    chk(rdat, 16'h76F9);
    step(4);
    chk(fault_ind_o, 1'b0);
    host_u.rd(addr, rdat, nak);
    chk(rdat, 16'h5010);
    parallel_i = 1'b1;
    short_gnd_i = 2'h2;
    step(2);
    short_gnd_i = 2'h0;
    step(6);
    host_u.rd(addr, rdat, nak);
    chk(rdat, 16'h5100);
    host_u.wr(addr, 24'h00_0000, nak);
    step(4);
    chk(fault_ind_o, 1'b1);
    summarize();
  end
endmodule

// ==== dv/acs_host_model.sv ====
`timescale 1ns/1ps
module acs_host_model (
  // Bus pins
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // Quarter of the 64 ns bus clock period
  localparam int Q = 16;
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Clock only toggles inside frames; idle is high
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_o = ~tx[i];
      #Q scl_o = 1'b1;
      #Q rx[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
  endtask
  task automatic start();
    sda_oe_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b0;
    #Q;
  endtask
  // Address then three bytes in order; nak set if any byte unacked
  task automatic wr(input logic [6:0] a, input logic [23:0] d, output logic nak);
    logic [8:0] rx;
    start();
    bits({a, 1'b0, 1'b1}, rx);
    nak = rx[0];
    for (int k = 2; k >= 0; k--) begin
      bits({d[k*8 +: 8], 1'b1}, rx);
      nak = nak | rx[0];
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic nak);
    logic [8:0] rx;
    start();
    bits({a, 1'b1, 1'b1}, rx);
    nak = rx[0];
    bits(9'h1FE, rx);
    d[15:8] = rx[8:1];
    // Last byte left unacked before the stop
    bits(9'h1FF, rx);
    d[7:0] = rx[8:1];
    stop();
  endtask
endmodule
